// file: hdl/mlbx_addsub.sv
// Eight bit adder and subtractor with the four arithmetic flags
`timescale 1ns/1ns
`default_nettype none
module mlbx_addsub
  import mlbx_pkg::*;
(
  input wire logic [7:0] x_i, // Left operand
  input wire logic [7:0] y_i, // Right operand
  input wire logic sub_i, // High for x minus y
  output logic [7:0] r_o, // Result
  output logic z_o, // Result is zero
  output logic c_o, // Carry out or borrow
  output logic ac_o, // Nibble carry or borrow
  output logic ov_o // Signed overflow
);
  logic [8:0] full;
  logic [4:0] low;
  assign full = sub_i ? ({1'b0, x_i} - {1'b0, y_i}) : ({1'b0, x_i} + {1'b0, y_i});
  assign low = sub_i ? ({1'b0, x_i[3:0]} - {1'b0, y_i[3:0]}) : ({1'b0, x_i[3:0]} + {1'b0, y_i[3:0]});
  assign r_o = full[7:0];
  assign z_o = (full[7:0] == 8'h00);
  assign c_o = full[8];
  assign ac_o = low[4];
  // Subtraction overflows when operand signs differ and the result sign differs from x
  assign ov_o = sub_i ? ((x_i[7] != y_i[7]) && (full[7] != x_i[7]))
                      : ((x_i[7] == y_i[7]) && (full[7] != x_i[7]));
endmodule : mlbx_addsub
`default_nettype wire

// file: hdl/mlbx_bitsel.sv
// Single bit select, set, clear and replace on one byte
`timescale 1ns/1ns
`default_nettype none
module mlbx_bitsel (
  input wire logic [7:0] d_i, // Byte in
  input wire logic [2:0] n_i, // Bit index
  input wire logic v_i, // Value for replace
  output logic bit_o, // Selected bit
  output logic [7:0] set_o, // Byte with bit forced high
  output logic [7:0] clr_o, // Byte with bit forced low
  output logic [7:0] rep_o // Byte with bit replaced by v_i
);
  logic [7:0] mask;
  assign mask = 8'h01 << n_i;
  assign bit_o = |(d_i & mask);
  assign set_o = d_i | mask;
  assign clr_o = d_i & ~mask;
  assign rep_o = v_i ? set_o : clr_o;
endmodule : mlbx_bitsel
`default_nettype wire

// file: hdl/mlbx_exec.sv
// Logic, bit and branch execution unit with AXI4-Lite register access
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mlbx_exec
  import mlbx_pkg::*;
#(
  parameter int PC_W = 12,
  parameter int MEM_D = 128
) (
  input wire logic core_clk_i, // 10 MHz clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [7:0] pin_i, // Port pin levels
  input wire logic int_req_i, // Pending interrupt request
  output logic [7:0] port_o, // Port output latch
  output logic [7:0] port_oe_o, // Port output enables
  output logic gie_o, // Global interrupt enable
  output logic int_o, // Gated interrupt to processor
  output logic wdt_clr_o, // Watchdog restart pulse
  output logic halt_core_o, // Core clock gated
  output logic halt_sys_o, // All system clocks stopped
  output logic chip_rst_o // Whole chip reset pulse
);
  // ********************
  // Bus slave
  // ********************
  logic aw_got_reg, w_got_reg, awr_reg, wr_reg, bv_reg, arr_reg, rv_reg;
  logic [7:0] awa_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [1:0] br_reg, rr_reg;
  logic aw_hs, w_hs, ar_hs, wr_do;
  assign aw_hs = s_axi_awvalid & awr_reg;
  assign w_hs = s_axi_wvalid & wr_reg;
  assign ar_hs = s_axi_arvalid & arr_reg;
  assign wr_do = aw_got_reg & w_got_reg & ~bv_reg;

  logic [7:0] maddr_reg, acc_reg, sp_reg;
  logic [PC_W-1:0] pc_reg;
  logic [31:0] instr_reg;
  logic fz_reg, fc_reg, fac_reg, fov_reg, skip_reg, gie_reg, soft_reg;
  logic hc_reg, hs_reg, irq_a_reg, irq_b_reg;
  mlbx_state_e st_reg;
  logic [7:0] mem [MEM_D];
  logic [7:0] io_reg [4];

  logic sel_instr, sel_core, sel_maddr, sel_mdata, sel_ctrl, wr_ok, issue;
  assign sel_instr = (awa_reg == MLBX_A_INSTR);
  assign sel_core = (awa_reg == MLBX_A_CORE);
  assign sel_maddr = (awa_reg == MLBX_A_MADDR);
  assign sel_mdata = (awa_reg == MLBX_A_MDATA);
  assign sel_ctrl = (awa_reg == MLBX_A_CTRL);
  // Instructions are refused while busy or halted
  assign issue = wr_do & sel_instr & (st_reg == ST_IDLE) & ~hc_reg & ~hs_reg;
  assign wr_ok = issue | sel_maddr | sel_ctrl | ((sel_core | sel_mdata) & (st_reg == ST_IDLE));
  logic sw_core, sw_mem, wake;
  assign sw_core = wr_do & sel_core & wr_ok & (&s_axi_wstrb);
  assign sw_mem = wr_do & sel_mdata & wr_ok & s_axi_wstrb[0];
  assign wake = wr_do & sel_ctrl & s_axi_wstrb[0] & wd_reg[0];

  logic [31:0] rmux;
  logic rhit;
  assign rhit = (s_axi_araddr == MLBX_A_INSTR) | (s_axi_araddr == MLBX_A_STAT)
              | (s_axi_araddr == MLBX_A_CORE) | (s_axi_araddr == MLBX_A_MADDR)
              | (s_axi_araddr == MLBX_A_MDATA) | (s_axi_araddr == MLBX_A_CTRL);
  assign rmux = (s_axi_araddr == MLBX_A_INSTR) ? instr_reg
              : (s_axi_araddr == MLBX_A_STAT) ? {23'h0, hs_reg, hc_reg, gie_reg, skip_reg,
                                                 st_reg != ST_IDLE, fov_reg, fac_reg, fc_reg, fz_reg}
              : (s_axi_araddr == MLBX_A_CORE) ? {4'h0, 12'(pc_reg), sp_reg, acc_reg}
              : (s_axi_araddr == MLBX_A_MADDR) ? {24'h0, maddr_reg}
              : (s_axi_araddr == MLBX_A_MDATA) ? {24'h0, mem[maddr_reg[6:0]]}
              : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awr_reg <= 1'b0;
      wr_reg <= 1'b0;
      bv_reg <= 1'b0;
      br_reg <= MLBX_RESP_OK;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
    end else begin
      awr_reg <= ~aw_got_reg & ~aw_hs;
      wr_reg <= ~w_got_reg & ~w_hs;
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
      end
      if (wr_do) begin
        bv_reg <= 1'b1;
        br_reg <= wr_ok ? MLBX_RESP_OK : MLBX_RESP_ERR;
      end else if (bv_reg & s_axi_bready) begin
        bv_reg <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      arr_reg <= 1'b0;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= MLBX_RESP_OK;
    end else begin
      arr_reg <= ~rv_reg & ~ar_hs;
      if (ar_hs) begin
        rv_reg <= 1'b1;
        rd_reg <= rmux;
        rr_reg <= rhit ? MLBX_RESP_OK : MLBX_RESP_ERR;
      end else if (rv_reg & s_axi_rready) begin
        rv_reg <= 1'b0;
      end
    end
  end

  // ********************
  // Decode
  // ********************
  logic rst_all;
  assign rst_all = sys_rst_i | soft_reg;
  logic [3:0] cls, sub;
  logic [1:0] form;
  logic [2:0] bn;
  logic [7:0] imm;
  logic [6:0] adr;
  logic [1:0] ioa;
  assign cls = instr_reg[MLBX_F_CLS +: 4];
  assign form = instr_reg[MLBX_F_FORM +: 2];
  assign bn = instr_reg[MLBX_F_BIT +: 3];
  assign sub = instr_reg[MLBX_F_BIT +: 4];
  assign imm = instr_reg[MLBX_F_IMM +: 8];
  assign adr = instr_reg[MLBX_F_ADR +: 7];
  assign ioa = instr_reg[MLBX_F_ADR +: 2];

  logic run, is_sys, lg, unop, to_mem, to_io, bitop;
  // A skipped instruction runs as a no-operation
  assign run = (st_reg == ST_EXEC) & ~skip_reg;
  assign is_sys = (cls == C_SYS);
  assign lg = (cls == C_AND) | (cls == C_OR) | (cls == C_XOR);
  assign unop = (cls == C_NOT) | (cls == C_NEG) | (cls == C_INCS) | (cls == C_DECS);
  assign to_mem = (form == F_MA);
  assign to_io = (form == F_IO);
  assign bitop = (cls == C_BCLR) | (cls == C_BSET) | (cls == C_TLOW) | (cls == C_THIGH);

  // ********************
  // Operands
  // ********************
  logic [7:0] pins_a_reg, pins_b_reg, mem_rd, io_rd, opnd, tv;
  assign mem_rd = mem[adr];
  // Port reads the latch on outputs and the pin on inputs
  assign io_rd = (ioa == IO_PORT) ? ((io_reg[IO_PORT] & io_reg[IO_DIR]) | (pins_b_reg & ~io_reg[IO_DIR]))
               : io_reg[ioa];
  assign opnd = (form == F_AI) ? imm : to_io ? io_rd : mem_rd;
  assign tv = to_mem ? mem_rd : acc_reg;

  logic [7:0] lres, as_x, as_y, as_r, bsrc, b_set, b_clr, b_rep;
  logic as_sub, as_z, as_c, as_ac, as_ov, b_bit;
  assign lres = (cls == C_AND) ? (acc_reg & opnd) : (cls == C_OR) ? (acc_reg | opnd) : (acc_reg ^ opnd);
  assign as_x = ((cls == C_CMP) & to_mem) ? mem_rd : ((cls == C_INCS) | (cls == C_DECS)) ? tv : acc_reg;
  assign as_y = ((cls == C_CMP) & to_mem) ? acc_reg : ((cls == C_INCS) | (cls == C_DECS)) ? 8'h01 : opnd;
  assign as_sub = (cls != C_INCS);

  mlbx_addsub u_as (
    .x_i(as_x),
    .y_i(as_y),
    .sub_i(as_sub),
    .r_o(as_r),
    .z_o(as_z),
    .c_o(as_c),
    .ac_o(as_ac),
    .ov_o(as_ov)
  );

  assign bsrc = to_io ? io_rd : mem_rd;
  mlbx_bitsel u_bit (
    .d_i(bsrc),
    .n_i(bn),
    .v_i(fc_reg),
    .bit_o(b_bit),
    .set_o(b_set),
    .clr_o(b_clr),
    .rep_o(b_rep)
  );

  // ********************
  // Results and write enables
  // ********************
  logic [7:0] wval;
  assign wval = lg ? lres
              : (cls == C_NOT) ? ~tv
              : (cls == C_NEG) ? 8'(~tv + 8'h01)
              // Set and clear on IO work on the latch, so input pins never leak into it
              : (cls == C_BSET) ? (to_io ? (io_reg[ioa] | (8'h01 << bn)) : b_set)
              : (cls == C_BCLR) ? (to_io ? (io_reg[ioa] & ~(8'h01 << bn)) : b_clr)
              : (cls == C_SWAPC) ? (io_reg[ioa] & ~(8'h01 << bn)) | (b_rep & (8'h01 << bn))
              : as_r;

  logic acc_we, mem_we, io_we, z_we, ar_we, c_swap, sys_op;
  assign sys_op = run & is_sys;
  assign acc_we = run & (lg | unop) & ~to_mem & ~to_io;
  assign mem_we = run & ((lg | unop) & to_mem | ((cls == C_BSET) | (cls == C_BCLR)) & ~to_io);
  assign io_we = run & ((cls == C_XOR) | (cls == C_BSET) | (cls == C_BCLR) | (cls == C_SWAPC)) & to_io;
  // Logic on an IO register keeps every flag
  assign z_we = run & (lg | (cls == C_NOT) | (cls == C_NEG)) & ~to_io;
  assign ar_we = run & ((cls == C_CMP) | (cls == C_CEQ) | (cls == C_CNE) | (cls == C_INCS) | (cls == C_DECS));
  assign c_swap = run & (cls == C_SWAPC) & to_io;

  logic skip_hit, two_t, rets, do_call;
  assign skip_hit = run & (((cls == C_CEQ) & as_z)
                         | ((cls == C_CNE) & ~as_z)
                         | ((cls == C_TLOW) & ~b_bit)
                         | ((cls == C_THIGH) & b_bit)
                         | (((cls == C_INCS) | (cls == C_DECS)) & as_z));
  assign rets = sys_op & ((sub == S_RET) | (sub == S_RETV) | (sub == S_RETI));
  assign do_call = sys_op & (sub == S_CALL);
  assign two_t = skip_hit | rets | do_call | (sys_op & ((sub == S_GOTO) | (sub == S_PCADD)));

  logic [7:0] sp_dn, sp_up;
  logic [PC_W-1:0] pc_inc, pc_stk, pc_next;
  assign sp_dn = 8'(sp_reg - MLBX_STEP);
  assign sp_up = 8'(sp_reg + MLBX_STEP);
  assign pc_inc = PC_W'(pc_reg + 1'b1);
  assign pc_stk = PC_W'({mem[7'(sp_dn + 8'h01)], mem[sp_dn[6:0]]});
  assign pc_next = (do_call | (sys_op & (sub == S_GOTO))) ? instr_reg[MLBX_F_IMM +: PC_W]
                 : rets ? pc_stk
                 : (sys_op & (sub == S_PCADD)) ? PC_W'(pc_reg + {{(PC_W-8){1'b0}}, acc_reg})
                 : pc_inc;

  // ********************
  // State
  // ********************
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      st_reg <= ST_IDLE;
      instr_reg <= 32'h0;
      skip_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (issue) begin
            st_reg <= ST_EXEC;
            instr_reg <= wd_reg;
          end
        end
        ST_EXEC: begin
          st_reg <= two_t ? ST_WAIT : ST_IDLE;
          skip_reg <= skip_hit;
        end
        ST_WAIT: st_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      acc_reg <= 8'h00;
      pc_reg <= '0;
      sp_reg <= MLBX_SP_RST;
      maddr_reg <= 8'h00;
    end else begin
      if (sw_core) begin
        acc_reg <= wd_reg[7:0];
        sp_reg <= wd_reg[15:8];
        pc_reg <= wd_reg[16 +: PC_W];
      end else if (st_reg == ST_EXEC) begin
        pc_reg <= pc_next;
        if (acc_we) acc_reg <= wval;
        if (sys_op & (sub == S_RETV)) acc_reg <= imm;
        if (do_call) sp_reg <= sp_up;
        if (rets) sp_reg <= sp_dn;
      end
      if (wr_do & sel_maddr & s_axi_wstrb[0]) maddr_reg <= wd_reg[7:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      fz_reg <= 1'b0;
      fc_reg <= 1'b0;
      fac_reg <= 1'b0;
      fov_reg <= 1'b0;
    end else if (ar_we) begin
      fz_reg <= as_z;
      fc_reg <= as_c;
      fac_reg <= as_ac;
      fov_reg <= as_ov;
    end else begin
      if (z_we) fz_reg <= (wval == 8'h00);
      if (c_swap) fc_reg <= b_bit;
    end
  end

  // Memory holds no reset value, as in real RAM
  always_ff @(posedge core_clk_i) begin
    if (mem_we) mem[adr] <= wval;
    if (do_call) begin
      mem[sp_reg[6:0]] <= pc_inc[7:0];
      mem[7'(sp_reg + 8'h01)] <= 8'(pc_inc >> 8);
    end
    if (sw_mem) mem[maddr_reg[6:0]] <= wd_reg[7:0];
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      for (int i = 0; i < 4; i++) io_reg[i] <= 8'h00;
    end else if (io_we) begin
      io_reg[ioa] <= (cls == C_XOR) ? (acc_reg ^ io_reg[ioa]) : wval;
    end
  end

  // ********************
  // System control
  // ********************
  always_ff @(posedge core_clk_i) begin
    if (rst_all) begin
      gie_reg <= 1'b0;
      hc_reg <= 1'b0;
      hs_reg <= 1'b0;
      wdt_clr_o <= 1'b0;
      int_o <= 1'b0;
    end else begin
      if (sys_op & ((sub == S_ENGI) | (sub == S_RETI))) gie_reg <= 1'b1;
      if (sys_op & (sub == S_DISGI)) gie_reg <= 1'b0;
      wdt_clr_o <= sys_op & (sub == S_WDCLR);
      if (sys_op & (sub == S_HALTC)) hc_reg <= 1'b1;
      else if (wake) hc_reg <= 1'b0;
      if (sys_op & (sub == S_HALTS)) hs_reg <= 1'b1;
      else if (wake) hs_reg <= 1'b0;
      int_o <= gie_reg & irq_b_reg;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      soft_reg <= 1'b0;
      chip_rst_o <= 1'b0;
      pins_a_reg <= 8'h00;
      pins_b_reg <= 8'h00;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      soft_reg <= sys_op & (sub == S_SWRST);
      chip_rst_o <= sys_op & (sub == S_SWRST);
      pins_a_reg <= pin_i;
      pins_b_reg <= pins_a_reg;
      irq_a_reg <= int_req_i;
      irq_b_reg <= irq_a_reg;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign port_o = io_reg[IO_PORT];
  assign port_oe_o = io_reg[IO_DIR];
  assign gie_o = gie_reg;
  assign halt_core_o = hc_reg;
  assign halt_sys_o = hs_reg;
endmodule : mlbx_exec
`default_nettype wire

// file: hdl/mlbx_pkg.sv
// Constants for the logic, bit and branch execution block
//
// Overview of operation
// - AND, OR, XOR of accumulator with immediate or memory; only zero flag changes.
// - XOR into an IO register writes the IO register back; no flag changes.
// - Complement inverts accumulator or memory byte; only zero flag changes.
// - Negate takes two's complement of accumulator or memory; only zero flag changes.
// - Compare sets all four flags from a subtraction, storing no result.
// - Bit set and clear force one IO or memory bit; nothing else changes.
// - Carry swap exchanges an IO bit with carry; only carry is affected.
// - Compare-skip-equal skips on equality and sets flags from accumulator minus operand.
// - Compare-skip-not-equal skips on difference and sets flags from accumulator minus operand.
// - Bit test skips when the bit is low or high; no flag changes.
// - Increment or decrement skip stores the result, sets flags, skips on zero.
// - Call stores the return address at the stack pointer, adds two, jumps.
// - Jump loads any program address, flags untouched.
// - Return subtracts two from the stack pointer and reloads the program counter.
// - Return with value loads the immediate into the accumulator, then returns.
// - Interrupt return returns and then sets the global interrupt enable.
// - Computed jump adds the unsigned accumulator to the program counter.
// - Global enable and disable gate pending interrupt requests to the processor.
// - Watchdog clear restarts the watchdog count, nothing else.
// - Full halt stops all system clocks, the deepest stop state.
// - Processor halt gates the core clock while oscillators keep running.
// - Software reset clears core, flags, IO and system control as a hardware reset does, but not the bus slave or input synchronisers.
// - Jump, call, computed jump and returns take two cycles, others one.
// - Skip instructions take two cycles when skipping, one otherwise.
package mlbx_pkg;
  // ********************
  // Register map
  // ********************
  localparam logic [7:0] MLBX_A_INSTR = 8'h00;
  localparam logic [7:0] MLBX_A_STAT = 8'h04;
  localparam logic [7:0] MLBX_A_CORE = 8'h08;
  localparam logic [7:0] MLBX_A_MADDR = 8'h0C;
  localparam logic [7:0] MLBX_A_MDATA = 8'h10;
  localparam logic [7:0] MLBX_A_CTRL = 8'h14;
  localparam logic [1:0] MLBX_RESP_OK = 2'h0;
  localparam logic [1:0] MLBX_RESP_ERR = 2'h2;
  localparam logic [7:0] MLBX_SP_RST = 8'h00;
  localparam logic [7:0] MLBX_STEP = 8'h02;
  // ********************
  // Instruction word fields
  // ********************
  localparam int MLBX_F_CLS = 0;
  localparam int MLBX_F_FORM = 4;
  localparam int MLBX_F_BIT = 8;
  localparam int MLBX_F_IMM = 16;
  localparam int MLBX_F_ADR = 24;
  // Operation classes
  localparam logic [3:0] C_AND = 4'h0, C_OR = 4'h1, C_XOR = 4'h2, C_NOT = 4'h3;
  localparam logic [3:0] C_NEG = 4'h4, C_CMP = 4'h5, C_BCLR = 4'h6, C_BSET = 4'h7;
  localparam logic [3:0] C_SWAPC = 4'h8, C_CEQ = 4'h9, C_CNE = 4'hA, C_TLOW = 4'hB;
  localparam logic [3:0] C_THIGH = 4'hC, C_INCS = 4'hD, C_DECS = 4'hE, C_SYS = 4'hF;
  // Operand forms
  localparam logic [1:0] F_AI = 2'h0, F_AM = 2'h1, F_MA = 2'h2, F_IO = 2'h3;
  // System sub-operations
  localparam logic [3:0] S_NOP = 4'h0, S_CALL = 4'h1, S_GOTO = 4'h2, S_RETV = 4'h3;
  localparam logic [3:0] S_RET = 4'h4, S_RETI = 4'h5, S_PCADD = 4'h6, S_ENGI = 4'h7;
  localparam logic [3:0] S_DISGI = 4'h8, S_WDCLR = 4'h9, S_HALTS = 4'hA, S_HALTC = 4'hB;
  localparam logic [3:0] S_SWRST = 4'hC;
  // IO register indices
  localparam logic [1:0] IO_PORT = 2'h0, IO_DIR = 2'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} mlbx_state_e;
endpackage : mlbx_pkg

// file: tb/mlbx_exec_assertions.sv
// Port checker for the execution block
`timescale 1ns/1ns
`default_nettype none
module mlbx_exec_chk (
  input wire logic core_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic s_axi_bvalid, // Write answer
  input wire logic [7:0] port_o, // Latch
  input wire logic gie_o, // Gate
  input wire logic int_req_i, // Request
  input wire logic int_o, // Gated request
  input wire logic wdt_clr_o, // Pulse
  input wire logic halt_core_o, // Core halt
  input wire logic halt_sys_o, // Full halt
  input wire logic chip_rst_o // Pulse
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****
  // Steps
  // ****
  // Pulses and halt changes trace back to a completed write
  sequence s_wr;
    s_axi_bvalid || $past(s_axi_bvalid);
  endsequence
  sequence s_clr;
    port_o == 8'h00 && !gie_o && !halt_core_o && !halt_sys_o;
  endsequence
  AST_INT_BLOCK: assert property (!gie_o |=> !int_o)
    else $error("request passed a closed gate");
  AST_INT_PASS: assert property ((int_req_i && gie_o && !chip_rst_o) [*3] |=> int_o)
    else $error("request held at an open gate");
  AST_WDT_PULSE: assert property (wdt_clr_o |-> s_wr ##1 !wdt_clr_o)
    else $error("bad watchdog pulse");
  AST_CHIP_PULSE: assert property (chip_rst_o |-> s_wr ##1 !chip_rst_o)
    else $error("bad chip reset pulse");
  AST_CHIP_CLEAR: assert property (chip_rst_o |-> ##[1:2] s_clr)
    else $error("state kept over chip reset");
  AST_HALT_SYS: assert property ($changed(halt_sys_o) |-> s_wr)
    else $error("full halt moved alone");
  AST_HALT_CORE: assert property ($changed(halt_core_o) |-> s_wr)
    else $error("core halt moved alone");
  AST_PORT_CAUSE: assert property ($changed(port_o) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(chip_rst_o) || $past(chip_rst_o, 2))
    else $error("port latch moved alone");
endmodule : mlbx_exec_chk
bind mlbx_exec mlbx_exec_chk i_chk (.core_clk_i, .sys_rst_i, .s_axi_bvalid, .port_o, .gie_o, .int_req_i,
  .int_o, .wdt_clr_o, .halt_core_o, .halt_sys_o, .chip_rst_o);
`default_nettype wire

// file: tb/mlbx_exec_tb.sv
// Self-checking bench for the execution block
`timescale 1ns/1ns
`default_nettype none
module mlbx_exec_tb import mlbx_pkg::*;;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pin_i = 8'hA5;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, int_req_i = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic gie_o, int_o, wdt_clr_o, halt_core_o, halt_sys_o, chip_rst_o, aw, w;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] port_o, port_oe_o;
  int mismatches = 0, checks_done = 0, cyc = 0, wdt_seen = 0;
  always #50 core_clk_i = ~core_clk_i;
  mlbx_exec i_dut (.core_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i,
    .int_req_i, .port_o, .port_oe_o, .gie_o, .int_o, .wdt_clr_o, .halt_core_o, .halt_sys_o, .chip_rst_o);
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (wdt_clr_o === 1'h1) wdt_seen <= wdt_seen + 1;
    if (cyc == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Address and data offered together, released one by one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) aw = 1'h1;
      if (s_axi_wready) w = 1'h1;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (!(aw && w));
    while (!s_axi_bvalid) @(posedge core_clk_i);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge core_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk_i); while (!s_axi_rvalid);
    q = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  function automatic logic [31:0] iw(input logic [3:0] c, input logic [1:0] f, input logic [23:0] x);
    return {x, 2'h0, f, c};
  endfunction : iw
  task automatic run(input logic [31:0] i);
    wr(MLBX_A_INSTR, i);
    do rd(MLBX_A_STAT); while (q[4] !== 1'h0);
  endtask : run
  task automatic step(input logic [31:0] i, input logic [7:0] acc, input logic [3:0] fl);
    run(i);
    rd(MLBX_A_CORE);
    chk(q[7:0], acc);
    rd(MLBX_A_STAT);
    chk(q[3:0], fl);
  endtask : step
  task automatic t_logic();
    wr(MLBX_A_CORE, 32'h38);
    wr(MLBX_A_MADDR, 32'h05);
    wr(MLBX_A_MDATA, 32'h42);
    step(iw(C_CMP, F_AM, 24'h050000), 8'h38, 4'h2);
    step(iw(C_AND, F_AI, 24'h00C300), 8'h00, 4'h3);
    step(iw(C_OR, F_AI, 24'h000500), 8'h05, 4'h2);
    step(iw(C_XOR, F_AI, 24'h000500), 8'h00, 4'h3);
    step(iw(C_NOT, F_AI, 24'h0), 8'hFF, 4'h2);
    step(iw(C_NEG, F_AI, 24'h0), 8'h01, 4'h2);
    step(iw(C_XOR, F_MA, 24'h050000), 8'h01, 4'h2);
    step(iw(C_CMP, F_MA, 24'h050000), 8'h01, 4'h0);
    rd(MLBX_A_MDATA);
    chk(q, 32'h43);
    run(iw(C_BSET, F_MA, 24'h050002));
    rd(MLBX_A_MDATA);
    chk(q, 32'h47);
  endtask : t_logic
  task automatic t_bits();
    run(iw(C_BSET, F_IO, 24'h010000));
    chk(port_oe_o, 8'h01);
    run(iw(C_BSET, F_IO, 24'h000007));
    chk(port_o, 8'h80);
    step(iw(C_SWAPC, F_IO, 24'h000007), 8'h01, 4'h2);
    step(iw(C_XOR, F_IO, 24'h0), 8'h01, 4'h2);
    chk(port_o, 8'h01);
    run(iw(C_BCLR, F_IO, 24'h0));
    chk(port_o, 8'h00);
    step(iw(C_SWAPC, F_IO, 24'h0), 8'h01, 4'h0);
    chk(port_o, 8'h01);
  endtask : t_bits
  task automatic t_skip();
    wr(MLBX_A_CORE, 32'h00100055);
    run(iw(C_CEQ, F_AI, 24'h005500));
    run(iw(C_BSET, F_IO, 24'h000003));
    rd(MLBX_A_CORE);
    chk({q, port_o}, 40'h0012005501);
    step(iw(C_CNE, F_AI, 24'h005500), 8'h55, 4'h1);
    run(iw(C_BSET, F_IO, 24'h000003));
    chk(port_o, 8'h09);
    // Bit 3 is an input pin held low while its latch is high: tests see the pin
    run(iw(C_THIGH, F_IO, 24'h000003));
    run(iw(C_BCLR, F_IO, 24'h000003));
    chk(port_o, 8'h01);
    run(iw(C_TLOW, F_IO, 24'h000003));
    run(iw(C_BSET, F_IO, 24'h000003));
    chk(port_o, 8'h01);
    wr(MLBX_A_CORE, 32'hFF);
    step(iw(C_INCS, F_AI, 24'h0), 8'h00, 4'h7);
    run(iw(C_BSET, F_IO, 24'h000003));
    chk(port_o, 8'h01);
  endtask : t_skip
  task automatic t_branch();
    wr(MLBX_A_CORE, 32'h01001000);
    run(iw(C_SYS, F_AI, 24'h023401));
    rd(MLBX_A_CORE);
    chk(q, 32'h02341200);
    wr(MLBX_A_MADDR, 32'h10);
    rd(MLBX_A_MDATA);
    chk(q, 32'h01);
    run(iw(C_SYS, F_AI, 24'h007703));
    rd(MLBX_A_CORE);
    chk(q, 32'h01011077);
    run(iw(C_SYS, F_AI, 24'h0ABC02));
    run(iw(C_SYS, F_AI, 24'h000006));
    run(iw(C_SYS, F_AI, 24'h0));
    rd(MLBX_A_CORE);
    chk(q, 32'h0B341077);
    int_req_i <= 1'h1;
    run(iw(C_SYS, F_AI, 24'h005001));
    run(iw(C_SYS, F_AI, 24'h000005));
    repeat (3) @(posedge core_clk_i);
    chk({gie_o, int_o}, 2'h3);
    run(iw(C_SYS, F_AI, 24'h000008));
    repeat (3) @(posedge core_clk_i);
    chk({gie_o, int_o}, 2'h0);
    run(iw(C_SYS, F_AI, 24'h000007));
    chk(gie_o, 1'h1);
  endtask : t_branch
  task automatic t_sys();
    run(iw(C_SYS, F_AI, 24'h000009));
    chk(wdt_seen, 1);
    run(iw(C_SYS, F_AI, 24'h00000B));
    chk({halt_sys_o, halt_core_o}, 2'h1);
    wr(MLBX_A_INSTR, 32'h0F);
    chk(rr, MLBX_RESP_ERR);
    wr(MLBX_A_CTRL, 32'h1);
    run(iw(C_SYS, F_AI, 24'h00000A));
    chk({halt_sys_o, halt_core_o}, 2'h2);
    wr(MLBX_A_CTRL, 32'h1);
    run(iw(C_SYS, F_AI, 24'h00000C));
    rd(MLBX_A_CORE);
    chk({q, port_o, port_oe_o, gie_o}, 49'h0);
    rd(8'h40);
    chk({q, rr}, {32'h0, MLBX_RESP_ERR});
    wr(8'h40, 32'h1);
    chk(rr, MLBX_RESP_ERR);
  endtask : t_sys
  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'h0;
    rd(MLBX_A_CORE);
    chk(q, {16'h0, MLBX_SP_RST, 8'h00});
    t_logic();
    t_bits();
    t_skip();
    t_branch();
    t_sys();
    complete_run();
  end
endmodule : mlbx_exec_tb
`default_nettype wire
